// >>> spc_ctrl_model.sv
// Motion controller model driving the pulse and direction pins
`timescale 1ns/10ps
module spc_ctrl_model (
	// Clock
	input wire logic clk_in,
	// Requests from the bench
	input wire logic go_in,
	input wire logic rev_sel_in,
	input wire logic dir_level_in,
	input wire logic updown_in,
	input wire logic falling_in,
	// Pins toward the drive
	output logic step_pin_out,
	output logic rev_pin_out
);
	logic [2:0] cnt = 3'h0;
	logic sel = 1'b0;
	logic act;
	// One pulse per request, later requests ignored until the count is back at zero after the idle cycles
	always_ff @(posedge clk_in) begin
		if (go_in && cnt == 3'h0) begin
			cnt <= 3'h6;
			sel <= rev_sel_in;
		end else if (cnt != 3'h0) begin
			cnt <= cnt - 3'h1;
		end
	end
	// Three cycles active then at least four idle, above the two-cycle minimum
	assign act = (cnt >= 3'h4);
	// Idle level sits opposite the level that the active edge reaches
	assign step_pin_out = (act && !sel) ? !falling_in : falling_in;
	assign rev_pin_out = updown_in ? ((act && sel) ? !falling_in : falling_in) : dir_level_in;
endmodule : spc_ctrl_model

// >>> spc_edge_detect.sv
// Synchroniser and active-edge detector for the two pulse inputs
`timescale 1ns/10ps
module spc_edge_detect
	import spc_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Pins and settings
	input wire logic step_pin_in,
	input wire logic dir_pin_in,
	input wire logic falling_in,
	input wire logic updown_in,
	// Events
	spc_edge_if.src ev
);
	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic fwd;
		logic rev;
	} spc_det_s;

	spc_det_s r;
	spc_det_s next_r;
	logic [1:0] act;

	// Two-stage sync, then edge compare on stages two and three
	always_comb begin
		next_r = r;
		next_r.s1 = {dir_pin_in, step_pin_in};
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		act = falling_in ? (r.s3 & ~r.s2) : (~r.s3 & r.s2);
		if (updown_in) begin
			next_r.fwd = act[0];
			next_r.rev = act[1];
		end else begin
			next_r.fwd = act[0] & r.s2[1];
			next_r.rev = act[0] & ~r.s2[1];
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign ev.fwd_pulse = r.fwd;
	assign ev.rev_pulse = r.rev;

	one_event_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!(r.fwd && r.rev) || updown_in) else $error("both directions in step mode");
endmodule : spc_edge_detect

// >>> spc_edge_if.sv
// Interface carrying accepted pulse events from the edge detector
`timescale 1ns/10ps
interface spc_edge_if;
	logic fwd_pulse;
	logic rev_pulse;
	modport src (output fwd_pulse, output rev_pulse);
	modport dst (input fwd_pulse, input rev_pulse);
endinterface : spc_edge_if

// >>> spc_pkg.sv
// Package with constants and types of the stepper pulse input and configuration block
package spc_pkg;
	// ************************************************
	// Timing
	// ************************************************
	localparam int CLK_HZ = 10000000;
	localparam int IDLE_TIME_MS = 1000;
	localparam int IDLE_CYCLES = (CLK_HZ / 1000) * IDLE_TIME_MS;
	localparam int SPEED_WIN_MS = 100;
	localparam int SPEED_WIN_CYCLES = (CLK_HZ / 1000) * SPEED_WIN_MS;
	localparam int FULL_SPEED_RPM = 400;
	localparam int FULL_STEPS_REV = 200;
	// ************************************************
	// Field layouts and codes
	// ************************************************
	localparam int CUR_W = 4;
	localparam int POS_W = 32;
	localparam logic [3:0] STEP_CODE_FULL = 4'hE;
	localparam logic [3:0] STEP_CODE_LOCK = 4'hF;
	localparam logic [3:0] STEP_CODE_DEC0 = 4'h8;
	localparam logic [6:0] IDLE_PERCENT = 7'h3C;
	localparam logic [6:0] FULL_PERCENT = 7'h64;
	localparam logic [2:0] CUR_SW_DEFAULT = 3'h7;
	localparam logic [3:0] ANGLE_SW_DEFAULT = 4'hF;

	typedef enum logic [1:0] {
		SPC_BOOT = 2'h0,
		SPC_RUN = 2'h1,
		SPC_LOCK = 2'h2
	} spc_mode_e;

	// Microsteps per full step for a step-angle code
	function automatic logic [8:0] spc_divisor(input logic [3:0] code);
		logic [8:0] d;
		d = 9'h001;
		if (!code[3]) begin
			d = 9'(9'h002 << code[2:0]);
		end else begin
			case (code[2:0])
				3'h0: d = 9'h005;
				3'h1: d = 9'h00A;
				3'h2: d = 9'h019;
				3'h3: d = 9'h032;
				3'h4: d = 9'h07D;
				3'h5: d = 9'h0FA;
				default: d = 9'h001;
			endcase
		end
		return d;
	endfunction : spc_divisor
endpackage : spc_pkg

// >>> spc_stepper_cfg.sv
// Top of the stepper pulse input and configuration block
`timescale 1ns/10ps
module spc_stepper_cfg
	import spc_pkg::*;
#(
	parameter int IDLE_COUNT = IDLE_CYCLES,
	parameter int SPEED_WINDOW = SPEED_WIN_CYCLES
)(
	// Clock and reset
	input wire logic clk_in,
	input wire logic sys_rst_in,
	// Controller pins
	input wire logic step_pin_in,
	input wire logic reverse_pulse_input_in,
	input wire logic enable_pin_in,
	// Switches and jumpers, 1 = off / second position
	input wire logic [2:0] current_level_switches_in,
	input wire logic idle_reduction_switch_in,
	input wire logic [3:0] step_angle_switches_in,
	input wire logic edge_select_jumper_in,
	input wire logic pulse_mode_jumper_in,
	input wire logic enable_polarity_jumper_in,
	input wire logic voltage_mode_jumper_in,
	input wire logic current_range_jumper_in,
	// Status toward the power stage
	output logic stage_on_out,
	output logic [CUR_W-1:0] current_level_out,
	output logic [6:0] current_percent_out,
	output logic idle_current_reduction_out,
	output logic factory_setup_lock_out,
	output logic full_step_active_out,
	output logic [POS_W-1:0] position_out,
	output logic step_pulse_out
);
	// ************************************************
	// State
	// ************************************************
	// Switches and jumpers as they arrive from the pins
	typedef struct packed {
		logic [2:0] cur_sw;
		logic low_range;
		logic reduce_en;
		logic [3:0] angle;
		logic falling;
		logic updown;
		logic en_high;
		logic vmode;
	} spc_cfg_s;

	typedef struct packed {
		spc_mode_e mode;
		logic [2:0] cur_sw;
		logic low_range;
		logic reduce_en;
		logic [3:0] angle;
		logic falling;
		logic updown;
		logic en_high;
		logic vmode;
		logic [1:0] en_sync;
		logic [23:0] idle_cnt;
		logic reduced;
		logic [23:0] win_cnt;
		logic [15:0] win_steps;
		logic fast;
		logic stage_on;
		logic [POS_W-1:0] pos;
		logic step;
		spc_cfg_s cfg_s1;
		spc_cfg_s cfg_s2;
		logic [CUR_W-1:0] level;
		logic [6:0] pct;
		logic lock;
		logic full;
	} spc_top_s;

	spc_top_s r;
	spc_top_s next_r;
	spc_edge_if ev_if ();
	logic [8:0] div;
	logic [15:0] fast_limit;
	logic moving;

	spc_edge_detect u_edge (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.step_pin_in(step_pin_in),
		.dir_pin_in(reverse_pulse_input_in),
		.falling_in(r.falling),
		.updown_in(r.updown),
		.ev(ev_if.src)
	);

	// ************************************************
	// Next-state logic
	// ************************************************
	always_comb begin
		next_r = r;
		div = spc_divisor(r.angle);
		// Steps per window that equal 400 rpm at the chosen division
		fast_limit = 16'((FULL_SPEED_RPM * FULL_STEPS_REV * SPEED_WIN_MS / 60000) * div);
		moving = (ev_if.fwd_pulse | ev_if.rev_pulse) && r.mode == SPC_RUN && r.stage_on;
		next_r.step = moving;
		next_r.en_sync = {r.en_sync[0], enable_pin_in};
		// Switches and jumpers pass two flip-flops before capture
		next_r.cfg_s1 = {current_level_switches_in, current_range_jumper_in,
			idle_reduction_switch_in, step_angle_switches_in, edge_select_jumper_in,
			pulse_mode_jumper_in, enable_polarity_jumper_in, voltage_mode_jumper_in};
		next_r.cfg_s2 = r.cfg_s1;
		unique case (r.mode)
			SPC_BOOT: begin
				// Capture settings once; never again until reset
				next_r.cur_sw = r.cfg_s2.cur_sw;
				next_r.low_range = r.cfg_s2.low_range;
				next_r.reduce_en = r.cfg_s2.reduce_en;
				next_r.angle = r.cfg_s2.angle;
				next_r.falling = r.cfg_s2.falling;
				next_r.updown = r.cfg_s2.updown;
				next_r.en_high = r.cfg_s2.en_high;
				next_r.vmode = r.cfg_s2.vmode;
				next_r.mode = (r.cfg_s2.angle == STEP_CODE_LOCK) ? SPC_LOCK : SPC_RUN;
			end
			SPC_RUN: begin
				// Stage power from the selected enable polarity
				next_r.stage_on = r.en_high ? r.en_sync[1] : ~r.en_sync[1];
				if (moving) begin
					next_r.pos = ev_if.fwd_pulse ? r.pos + POS_W'(1) : r.pos - POS_W'(1);
					next_r.idle_cnt = '0;
					next_r.reduced = 1'b0;
				end else if (r.idle_cnt >= 24'(IDLE_COUNT - 1)) begin
					next_r.reduced = r.reduce_en;
				end else begin
					next_r.idle_cnt = r.idle_cnt + 24'h000001;
				end
				// Speed estimate over a fixed window
				if (r.win_cnt >= 24'(SPEED_WINDOW - 1)) begin
					next_r.win_cnt = '0;
					next_r.win_steps = '0;
					next_r.fast = r.vmode && (r.win_steps > fast_limit);
				end else begin
					next_r.win_cnt = r.win_cnt + 24'h000001;
					if (moving && r.win_steps != 16'hFFFF) begin
						next_r.win_steps = r.win_steps + 16'h0001;
					end
				end
			end
			SPC_LOCK: begin
				next_r.stage_on = 1'b0;
			end
			default: begin
				next_r.mode = SPC_BOOT;
			end
		endcase
		// Output registers, loaded from the next state so that they never lag it
		next_r.level = {~next_r.low_range, next_r.cur_sw};
		next_r.pct = next_r.reduced ? IDLE_PERCENT : FULL_PERCENT;
		next_r.lock = (next_r.mode == SPC_LOCK);
		next_r.full = next_r.fast || next_r.angle == STEP_CODE_FULL;
	end

	// ************************************************
	// Registers
	// ************************************************
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			r <= '0;
			r.mode <= SPC_BOOT;
			r.cur_sw <= CUR_SW_DEFAULT;
			r.reduce_en <= 1'b1;
			r.angle <= ANGLE_SW_DEFAULT;
			r.level <= {1'b1, CUR_SW_DEFAULT};
			r.pct <= FULL_PERCENT;
			// Synchronisers keep running so capture sees settled pins at release
			r.en_sync <= next_r.en_sync;
			r.cfg_s1 <= next_r.cfg_s1;
			r.cfg_s2 <= next_r.cfg_s2;
		end else begin
			r <= next_r;
		end
	end

	// ************************************************
	// Outputs
	// ************************************************
	assign stage_on_out = r.stage_on;
	assign current_level_out = r.level;
	assign current_percent_out = r.pct;
	assign idle_current_reduction_out = r.reduced;
	assign factory_setup_lock_out = r.lock;
	assign full_step_active_out = r.full;
	assign position_out = r.pos;
	assign step_pulse_out = r.step;

	// ************************************************
	// Checks
	// ************************************************
	cfg_frozen_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		$past(r.mode) != SPC_BOOT |-> $stable(r.cur_sw) && $stable(r.angle) && $stable(r.level))
		else $error("settings changed after capture");
	level_map_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		r.mode == SPC_BOOT |=>
		current_level_out == {~$past(r.cfg_s2.low_range), $past(r.cfg_s2.cur_sw)})
		else $error("bad level");
	max_default_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		r.mode == SPC_BOOT && r.cfg_s2.cur_sw == CUR_SW_DEFAULT && !r.cfg_s2.low_range |=>
		current_level_out == 4'hF) else $error("default not maximum");
	idle_drop_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		r.reduced |-> r.reduce_en && r.idle_cnt >= 24'(IDLE_COUNT - 1))
		else $error("reduced too early");
	restore_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		moving |=> !r.reduced && r.idle_cnt == 24'h0) else $error("not restored");
	reduce_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!r.reduce_en |-> !r.reduced) else $error("reduced while disabled");
	lock_still_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		r.mode == SPC_LOCK |=> $stable(r.pos) && !r.stage_on) else $error("moved in lock");
	enable_pol_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		r.mode == SPC_RUN |=> r.stage_on == (r.en_high ~^ $past(r.en_sync[1])))
		else $error("enable polarity");
	one_step_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		moving && ev_if.fwd_pulse |=> r.pos == $past(r.pos) + POS_W'(1))
		else $error("position step");
	fast_vmode_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		r.fast |-> r.vmode) else $error("full step without voltage mode");
	step_c: cover property (@(posedge clk_in) moving);
	reduce_c: cover property (@(posedge clk_in) r.reduced ##1 !r.reduced);
	lock_c: cover property (@(posedge clk_in) r.mode == SPC_LOCK);
	fast_c: cover property (@(posedge clk_in) r.fast);
endmodule : spc_stepper_cfg

// >>> testbench.sv
// Self-checking bench for the stepper pulse input and configuration block
`timescale 1ns/10ps
module testbench;
	import spc_pkg::*;
	typedef struct packed {
		logic [2:0] cur; logic rng; logic idl; logic [3:0] ang; logic edg; logic mdu;
		logic pol; logic en; logic dir; logic rv; logic [3:0] lvl; logic lock; logic stg;
		logic full; logic [7:0] pos;
	} spc_row_s;
	logic clk_in = 1'b0, sys_rst_in = 1'b1, go = 1'b0, rev_sel = 1'b0, dir_lvl = 1'b0;
	logic en_pin = 1'b0, rng = 1'b0, idl = 1'b1, edg = 1'b0, mdu = 1'b0, pol = 1'b0;
	logic vmd = 1'b0;
	logic [2:0] cur_sw = 3'h7;
	logic [3:0] ang = 4'hF;
	logic step_pin, rev_pin, stage_on, reduced, lock, full, step_pulse;
	logic [CUR_W-1:0] lvl;
	logic [6:0] pct;
	logic [POS_W-1:0] pos, p0;
	int num_errors = 0, tests_run = 0, cycles = 0, n_steps = 0, n0 = 0;
	spc_row_s r;
	spc_row_s rows [9] = '{
		'{3'h7, 1'h0, 1'h1, 4'hF, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 4'hF, 1'h1, 1'h0, 1'h0, 8'h00},
		'{3'h2, 1'h1, 1'h1, 4'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 4'h2, 1'h0, 1'h1, 1'h0, 8'h02},
		'{3'h5, 1'h0, 1'h1, 4'h3, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 4'hD, 1'h0, 1'h1, 1'h0, 8'hFE},
		'{3'h0, 1'h0, 1'h0, 4'h8, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 4'h8, 1'h0, 1'h1, 1'h0, 8'hFE},
		'{3'h1, 1'h1, 1'h1, 4'h9, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 4'h1, 1'h0, 1'h1, 1'h0, 8'h02},
		'{3'h3, 1'h0, 1'h1, 4'h4, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 4'hB, 1'h0, 1'h0, 1'h0, 8'h00},
		'{3'h3, 1'h0, 1'h1, 4'h4, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 4'hB, 1'h0, 1'h1, 1'h0, 8'h02},
		'{3'h3, 1'h0, 1'h1, 4'h4, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 4'hB, 1'h0, 1'h0, 1'h0, 8'h00},
		'{3'h6, 1'h1, 1'h1, 4'hE, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 4'h6, 1'h0, 1'h1, 1'h1, 8'h02}};

	// ************************************************
	// Clock, design, partner and timeout
	// ************************************************
	always #50 clk_in = !clk_in;
	spc_stepper_cfg #(.IDLE_COUNT(50), .SPEED_WINDOW(2000)) i_spc_stepper_cfg (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .step_pin_in(step_pin),
		.reverse_pulse_input_in(rev_pin), .enable_pin_in(en_pin),
		.current_level_switches_in(cur_sw), .idle_reduction_switch_in(idl),
		.step_angle_switches_in(ang), .edge_select_jumper_in(edg),
		.pulse_mode_jumper_in(mdu), .enable_polarity_jumper_in(pol),
		.voltage_mode_jumper_in(vmd), .current_range_jumper_in(rng),
		.stage_on_out(stage_on), .current_level_out(lvl), .current_percent_out(pct),
		.idle_current_reduction_out(reduced), .factory_setup_lock_out(lock),
		.full_step_active_out(full), .position_out(pos), .step_pulse_out(step_pulse));
	spc_ctrl_model i_spc_ctrl_model (.clk_in(clk_in), .go_in(go), .rev_sel_in(rev_sel),
		.dir_level_in(dir_lvl), .updown_in(mdu), .falling_in(edg),
		.step_pin_out(step_pin), .rev_pin_out(rev_pin));
	// Cycle limit and a count of the one-cycle step pulses
	always @(posedge clk_in) begin
		cycles++;
		if (step_pulse === 1'b1) begin
			n_steps++;
		end
		if (cycles == 6000) begin
			num_errors++;
			wrap_up();
		end
	end

	// ************************************************
	// Tasks
	// ************************************************
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Apply a row's settings, then reset so that they are captured
	task setup(input spc_row_s s);
		cur_sw <= s.cur; rng <= s.rng; idl <= s.idl; ang <= s.ang; edg <= s.edg;
		mdu <= s.mdu; pol <= s.pol; en_pin <= s.en; dir_lvl <= s.dir;
		sys_rst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (7) @(posedge clk_in);
	endtask : setup
	// One pulse from the controller, then let the pipeline settle
	task send(input logic rv);
		rev_sel <= rv;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		repeat (12) @(posedge clk_in);
	endtask : send
	task wrap_up;
		$display("Checks run %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		foreach (rows[i]) begin
			setup(rows[i]);
			check("level", 32'(lvl), 32'(rows[i].lvl));
			check("lock", 32'(lock), 32'(rows[i].lock));
			check("stage", 32'(stage_on), 32'(rows[i].stg));
			check("full", 32'(full), 32'(rows[i].full));
			p0 = pos;
			n0 = n_steps;
			send(rows[i].rv);
			send(rows[i].rv);
			check("moved", pos - p0, {{24{rows[i].pos[7]}}, rows[i].pos});
			check("pulses", n_steps - n0, (rows[i].pos == 8'h00) ? 32'h0 : 32'h2);
		end
		// Every step-angle code: only 15 locks, only 14 is full step
		for (int a = 0; a < 16; a++) begin
			r = rows[1];
			r.ang = 4'(a);
			setup(r);
			check("code lock", 32'(lock), 32'(a == 15));
			check("code full", 32'(full), 32'(a == 14));
		end
		// Switch changes after capture have no effect
		setup(rows[1]);
		cur_sw <= 3'h7;
		rng <= 1'b0;
		ang <= 4'hF;
		repeat (5) @(posedge clk_in);
		check("held level", 32'(lvl), 32'h2);
		check("held lock", 32'(lock), 32'h0);
		// Idle reduction measured from the last step and lifted by a new one
		// The step lands just before the count from reset would expire
		setup(rows[1]);
		repeat (30) @(posedge clk_in);
		send(1'b0);
		repeat (30) @(posedge clk_in);
		check("early idle", 32'(reduced), 32'h0);
		repeat (20) @(posedge clk_in);
		check("idle", 32'(reduced), 32'h1);
		check("idle pct", 32'(pct), 32'(IDLE_PERCENT));
		send(1'b0);
		check("restored", 32'(reduced), 32'h0);
		check("full pct", 32'(pct), 32'(FULL_PERCENT));
		// Reduction switch on keeps nominal current
		setup(rows[3]);
		repeat (80) @(posedge clk_in);
		check("no idle", 32'(reduced), 32'h0);
		// Voltage mode: dense half-step pulses turn full step on, a quiet window off
		vmd <= 1'b1;
		setup(rows[1]);
		rev_sel <= 1'b0;
		go <= 1'b1;
		repeat (2100) @(posedge clk_in);
		check("fast", 32'(full), 32'h1);
		go <= 1'b0;
		repeat (2000) @(posedge clk_in);
		check("slow", 32'(full), 32'h0);
		wrap_up();
	end
endmodule : testbench
